// ===== verilog/eeh_pkg.sv
// Timing constants, counter types and sequencer states for the parallel EEPROM host
package eeh_pkg;

  // System clock rate
  localparam int CLK_MHZ = 50;

  // Pin timing figures as printed, in their own units
  localparam int T_ACC_NS = 150;
  localparam int T_OHZ_NS = 50;
  localparam int T_OES_NS = 10;
  localparam int T_WP_NS = 100;
  localparam int T_AH_NS = 50;
  localparam int T_WPH_NS = 100;
  localparam int T_PROG_MS = 5;
  localparam int T_BLC_US = 100;

  // Cycles spent by the input synchroniser before a pin change is seen
  localparam int SYNC_LAT = 4;

  // Least time in ns to whole cycles, never below one
  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  localparam int C_ACC = cyc_ceil(T_ACC_NS) + SYNC_LAT;
  localparam int C_OHZ = cyc_ceil(T_OHZ_NS);
  localparam int C_OES = cyc_ceil(T_OES_NS);
  localparam int C_WP = cyc_ceil(T_WP_NS);
  localparam int C_AH = cyc_ceil(T_AH_NS);
  localparam int C_WPH = cyc_ceil(T_WPH_NS);
  // Longest times convert exactly, with no rounding
  localparam int C_PROG = T_PROG_MS * CLK_MHZ * 1000;
  localparam int C_BLC = T_BLC_US * CLK_MHZ;

  // Reset value of the strobe pin drivers
  localparam logic RST_STROBE = 1'b1;

  typedef logic [3:0] eeh_cnt_t;
  typedef logic [17:0] eeh_long_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_RD,
    ST_RD_REC,
    ST_WR_SET,
    ST_WR_PULSE,
    ST_WR_HOLD,
    ST_WR_GAP,
    ST_PROG
  } eeh_state_t;

endpackage : eeh_pkg

// ===== verilog/eeh_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module eeh_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Asynchronous input and filtered result
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= i_d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filters a value caught mid-transition on one stage only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= '0;
    end else if (s2 == s3) begin
      o_q <= s3;
    end
  end
endmodule : eeh_sync

// ===== verilog/eeh_ctrl.sv
// Host-side sequencer driving a bytewide self-timed EEPROM through its strobe pins
`timescale 1ns/1ps
module eeh_ctrl
  import eeh_pkg::*;
#(
  parameter int AW = 16,
  parameter int DW = 8,
  parameter int T_PROG_CYC = eeh_pkg::C_PROG,
  parameter int T_BLC_CYC = eeh_pkg::C_BLC
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // User requests
  input wire logic I_RD,
  input wire logic I_WR,
  input wire logic I_MORE,
  input wire logic I_POLL_EN,
  input wire logic [AW-1:0] I_ADDR,
  input wire logic [DW-1:0] I_WDATA,
  // User answers
  output logic O_READY,
  output logic O_RVALID,
  output logic [DW-1:0] O_RDATA,
  output logic O_WDONE,
  output logic O_PAGE_OPEN,
  output logic O_PROG_BUSY,
  // Memory pins
  output logic O_CE_N,
  output logic O_OE_N,
  output logic O_WE_N,
  output logic [AW-1:0] O_ADDR,
  output logic [DW-1:0] O_DATA_PINS_O,
  output logic O_DATA_PINS_OE,
  input wire logic [DW-1:0] I_DATA_PINS_I
);
  import eeh_pkg::*;

  eeh_state_t state;
  eeh_cnt_t cnt;
  eeh_long_t wc_cnt;
  eeh_long_t blc_cnt;
  logic more;
  logic polling;
  logic poll_en;
  logic have_prev;
  logic poll_hit;
  logic [DW-1:0] prev;
  logic [DW-1:0] dq_in;
  logic rd_done;
  logic gap_end;
  logic blc_out;
  logic start_prog;
  logic prog_end;

  eeh_sync #(.W(DW)) u_dq_sync (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_d(I_DATA_PINS_I),
    .o_q(dq_in)
  );

  assign rd_done = (state == ST_RD) && (cnt == '0);
  assign gap_end = (state == ST_WR_GAP) && (cnt == '0);
  assign blc_out = O_PAGE_OPEN && (blc_cnt == '0);
  // A page left idle too long is closed, since the device starts programming on its own
  assign start_prog = (gap_end && !more) || ((state == ST_IDLE) && blc_out);
  assign prog_end = (state == ST_PROG) && (poll_hit || (wc_cnt == '0));

  assign O_READY = (state == ST_IDLE) && !blc_out;
  assign O_PROG_BUSY = (state == ST_PROG) || polling;

  // Bus sequencing and pin drivers
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= ST_IDLE;
      cnt <= '0;
      O_CE_N <= RST_STROBE;
      O_OE_N <= RST_STROBE;
      O_WE_N <= RST_STROBE;
      O_ADDR <= '0;
      O_DATA_PINS_O <= '0;
      O_DATA_PINS_OE <= 1'b0;
      more <= 1'b0;
      polling <= 1'b0;
      poll_en <= 1'b0;
      O_PAGE_OPEN <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (blc_out) begin
            O_PAGE_OPEN <= 1'b0;
            state <= ST_PROG;
          end else if (I_WR) begin
            // Gate stays high across the load so the device cannot see a read
            O_ADDR <= I_ADDR;
            O_DATA_PINS_O <= I_WDATA;
            more <= I_MORE;
            poll_en <= I_POLL_EN;
            O_CE_N <= 1'b0;
            O_DATA_PINS_OE <= 1'b1;
            cnt <= eeh_cnt_t'(C_OES - 1);
            state <= ST_WR_SET;
          end else if (I_RD && !O_PAGE_OPEN) begin
            O_ADDR <= I_ADDR;
            O_CE_N <= 1'b0;
            O_OE_N <= 1'b0;
            polling <= 1'b0;
            cnt <= eeh_cnt_t'(C_ACC - 1);
            state <= ST_RD;
          end
        end
        ST_RD: begin
          if (cnt == '0) begin
            O_CE_N <= 1'b1;
            O_OE_N <= 1'b1;
            cnt <= eeh_cnt_t'(C_OHZ - 1);
            state <= ST_RD_REC;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_RD_REC: begin
          // Lets the device release the data pins before anything else drives them
          if (cnt == '0) begin
            state <= polling ? ST_PROG : ST_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_WR_SET: begin
          if (cnt == '0) begin
            O_WE_N <= 1'b0;
            cnt <= eeh_cnt_t'(C_WP - 1);
            state <= ST_WR_PULSE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_WR_PULSE: begin
          if (cnt == '0) begin
            O_WE_N <= 1'b1;
            cnt <= eeh_cnt_t'(C_AH - 1);
            state <= ST_WR_HOLD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_WR_HOLD: begin
          if (cnt == '0) begin
            O_CE_N <= 1'b1;
            O_DATA_PINS_OE <= 1'b0;
            cnt <= eeh_cnt_t'(C_WPH - 1);
            state <= ST_WR_GAP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_WR_GAP: begin
          if (cnt == '0) begin
            O_PAGE_OPEN <= more;
            state <= more ? ST_IDLE : ST_PROG;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_PROG: begin
          if (prog_end) begin
            polling <= 1'b0;
            state <= ST_IDLE;
          end else if (poll_en) begin
            // Poll is a plain read of the last written address
            O_CE_N <= 1'b0;
            O_OE_N <= 1'b0;
            polling <= 1'b1;
            cnt <= eeh_cnt_t'(C_ACC - 1);
            state <= ST_RD;
          end
        end
      endcase
    end
  end

  // Program wait, capped at the device's worst case
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      wc_cnt <= '0;
    end else if (start_prog) begin
      wc_cnt <= eeh_long_t'(T_PROG_CYC - 1);
    end else if (wc_cnt != '0) begin
      wc_cnt <= wc_cnt - 1'b1;
    end
  end

  // Byte load window of an open page
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      blc_cnt <= '0;
    end else if (gap_end && more) begin
      blc_cnt <= eeh_long_t'(T_BLC_CYC - 1);
    end else if (blc_cnt != '0) begin
      blc_cnt <= blc_cnt - 1'b1;
    end
  end

  // Completion poll: two equal reads in a row mean programming has ended
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      prev <= '0;
      have_prev <= 1'b0;
      poll_hit <= 1'b0;
    end else if (start_prog) begin
      have_prev <= 1'b0;
      poll_hit <= 1'b0;
    end else if (rd_done && polling) begin
      prev <= dq_in;
      have_prev <= 1'b1;
      poll_hit <= have_prev && (dq_in == prev);
    end
  end

  // User answers
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RDATA <= '0;
      O_RVALID <= 1'b0;
      O_WDONE <= 1'b0;
    end else begin
      O_RVALID <= rd_done && !polling;
      O_WDONE <= prog_end;
      if (rd_done && !polling) begin
        O_RDATA <= dq_in;
      end
    end
  end

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);

  sequence read_phase_s;
    !O_CE_N && !O_OE_N && O_WE_N && !O_DATA_PINS_OE;
  endsequence

  sequence write_pulse_s;
    !O_CE_N && O_OE_N && !O_WE_N && O_DATA_PINS_OE;
  endsequence

  strobe_excl_a: assert property (!(!O_OE_N && !O_WE_N))
    else $error("output gate and write strobe low together");
  read_hold_a: assert property ($fell(O_OE_N) |-> read_phase_s [*8])
    else $error("read phase cut short or malformed");
  we_width_a: assert property ($fell(O_WE_N) |-> write_pulse_s [*5])
    else $error("write strobe pulse too short");
  data_hold_a: assert property ($rose(O_WE_N) |-> (O_DATA_PINS_OE && !O_CE_N) [*3])
    else $error("data or select released before hold");
  prog_quiet_a: assert property (state == ST_PROG |-> O_WE_N && O_CE_N)
    else $error("access during internal programming");
  prog_end_a: assert property (O_WDONE |-> ($past(state) == ST_PROG) &&
    (($past(wc_cnt) == '0) || $past(poll_hit)))
    else $error("write done before program time or poll match");
  poll_read_a: assert property ($rose(poll_hit) |-> $past(rd_done) && $past(polling))
    else $error("poll match not taken from a read");
  page_gap_a: assert property (state == ST_IDLE && O_PAGE_OPEN |-> O_CE_N && O_WE_N)
    else $error("pins active between page byte loads");
  poll_gap_a: assert property (polling && !O_OE_N |-> O_WE_N && !O_CE_N)
    else $error("poll read with wrong strobes");
endmodule : eeh_ctrl

// ===== tb/eeh_mem_model.sv
// Behavioural bytewide self-timed memory answering the host strobes
`timescale 1ns/1ps
module eeh_mem_model #(
  parameter int PROG_NS = 1500
) (
  // Strobes and address
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic [15:0] i_addr,
  // Data pins
  input wire logic [7:0] i_dq,
  output logic [7:0] o_dq,
  output logic o_drv
);
  logic [7:0] mem [0:255];
  logic tog = 1'b0;
  time t_wr = 0;

  // Latch on the trailing strobe edge; gate low inhibits the write
  always @(posedge i_we_n or posedge i_ce_n) begin
    if ((i_ce_n != i_we_n) && i_oe_n) begin
      mem[i_addr[7:0]] = i_dq;
      t_wr = $time;
    end
  end

  // Each read while busy flips one bit, so no two successive polls agree
  always @(negedge i_oe_n) begin
    if (!i_ce_n) begin
      tog = ~tog;
    end
  end

  always @* begin
    o_drv = !i_ce_n && !i_oe_n && i_we_n;
    if ($time - t_wr < PROG_NS) begin
      o_dq = {tog, ~mem[i_addr[7:0]][6:0]};
    end else begin
      o_dq = mem[i_addr[7:0]];
    end
  end
endmodule : eeh_mem_model

// ===== tb/async_eeprom_bus_mode_and_write_control_bench.sv
// Self-checking bench for the parallel memory host sequencer
`timescale 1ns/1ps
module async_eeprom_bus_mode_and_write_control_bench;
  import eeh_pkg::*;
  localparam int WC = 200;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic more = 1'b0;
  logic poll = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic ready, rvalid, wdone, page_open, prog_busy, ce_n, oe_n, we_n, dq_oe, m_drv;
  logic [15:0] pin_addr;
  logic [7:0] rdata, dq_o, m_dq;
  logic [7:0] last_bus = 8'h00;
  wire [7:0] bus;
  int bad_count = 0;
  int samples_checked = 0;

  // A released bus shows the inverse of its last level, never a held copy
  assign bus = dq_oe ? dq_o : m_drv ? m_dq : ~last_bus;
  always @(bus) if (dq_oe || m_drv) last_bus = bus;
  always #10 clk = ~clk;

  localparam int BLC = 100;
  eeh_ctrl #(.T_PROG_CYC(WC), .T_BLC_CYC(BLC)) u_eeh_ctrl (
    .I_CLK_SYS(clk), .I_NRST(nrst), .I_RD(rd), .I_WR(wr), .I_MORE(more),
    .I_POLL_EN(poll), .I_ADDR(addr), .I_WDATA(wdata), .O_READY(ready),
    .O_RVALID(rvalid), .O_RDATA(rdata), .O_WDONE(wdone), .O_PAGE_OPEN(page_open),
    .O_PROG_BUSY(prog_busy), .O_CE_N(ce_n), .O_OE_N(oe_n), .O_WE_N(we_n),
    .O_ADDR(pin_addr), .O_DATA_PINS_O(dq_o), .O_DATA_PINS_OE(dq_oe),
    .I_DATA_PINS_I(bus));

  eeh_mem_model #(.PROG_NS(1500)) u_eeh_mem_model (
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(pin_addr),
    .i_dq(bus), .o_dq(m_dq), .o_drv(m_drv));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Waits on ready (0), read valid (1) or write done (2)
  task automatic wait_sig(input int w, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        bad_count++;
        wrap_up();
      end
    end while ((w == 0 ? ready : w == 1 ? rvalid : wdone) !== 1'b1);
  endtask : wait_sig

  task automatic do_write(input logic [15:0] a, input logic [7:0] d, input logic m, p);
    int n;
    wait_sig(0, 400, n);
    wr = 1'b1;
    addr = a;
    wdata = d;
    more = m;
    poll = p;
    @(negedge clk);
    wr = 1'b0;
  endtask : do_write

  task automatic do_read(input logic [15:0] a, output logic [7:0] d);
    int n;
    wait_sig(0, 400, n);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    wait_sig(1, 40, n);
    d = rdata;
  endtask : do_read

  // Gate low means a read: strobe must stay high and the host off the bus
  always @(negedge clk) begin
    if (nrst && oe_n === 1'b0) begin
      chk("we_n_in_read", {15'h0, we_n}, 16'h1);
      chk("host_drive_in_read", {15'h0, dq_oe}, 16'h0);
    end
  end

  task automatic t_reset;
    chk("idle_strobes", {13'h0, ce_n, oe_n, we_n}, 16'h7);
    chk("idle_drive", {15'h0, dq_oe}, 16'h0);
    chk("idle_ready", {15'h0, ready}, 16'h1);
  endtask : t_reset

  task automatic t_single;
    int n;
    logic [7:0] d;
    do_write(16'h0012, 8'ha5, 1'b0, 1'b0);
    // Byte load takes about fifteen cycles, so this lands inside the program wait
    repeat (20) @(negedge clk);
    chk("busy_in_prog", {14'h0, prog_busy, ready}, 16'h2);
    wait_sig(2, WC + 100, n);
    chk("full_wait", {15'h0, n + 20 >= WC}, 16'h1);
    chk("busy_after", {15'h0, prog_busy}, 16'h0);
    do_read(16'h0012, d);
    chk("single_rd", {8'h0, d}, 16'h00a5);
  endtask : t_single

  task automatic t_poll;
    int n;
    logic [7:0] d;
    do_write(16'h0034, 8'h5a, 1'b0, 1'b1);
    wait_sig(2, WC + 100, n);
    chk("poll_early", {15'h0, n < WC}, 16'h1);
    do_read(16'h0034, d);
    chk("poll_rd", {8'h0, d}, 16'h005a);
  endtask : t_poll

  task automatic t_page;
    int n;
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      do_write(16'h0040 + 16'(i), 8'hc0 + 8'(i), i < 2, 1'b0);
      // The page flag only moves once the byte load has finished
      repeat (20) @(negedge clk);
      chk("page_open", {15'h0, page_open}, {15'h0, i < 2});
    end
    wait_sig(2, WC + 400, n);
    for (int i = 0; i < 3; i++) begin
      do_read(16'h0040 + 16'(i), d);
      chk("page_rd", {8'h0, d}, 16'h00c0 + 16'(i));
    end
  endtask : t_page

  // A page left without a further load closes itself and then programs
  task automatic t_expire;
    int n;
    logic [7:0] d;
    do_write(16'h0050, 8'h3c, 1'b1, 1'b0);
    wait_sig(2, BLC + WC + 100, n);
    chk("expire_wait", {15'h0, n >= BLC + WC}, 16'h1);
    chk("expire_closed", {15'h0, page_open}, 16'h0);
    do_read(16'h0050, d);
    chk("expire_rd", {8'h0, d}, 16'h003c);
  endtask : t_expire

  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_single();
    t_poll();
    t_page();
    t_expire();
    wrap_up();
  end
endmodule : async_eeprom_bus_mode_and_write_control_bench
